// File: hes_map.vh
// register map, field positions and reset values of the host endian-swap / power-save port
`ifndef HES_MAP_VH
`define HES_MAP_VH
// register indices; byte address is four times the index
`define HES_IDX_DISP_CTRL 8'h71
`define HES_IDX_PSAVE 8'hA0
`define HES_IDX_IRQ_STAT 8'hA4
`define HES_IDX_IRQ_MASK 8'hA5
`define HES_IDX_MEM_ADDR 8'hA8
`define HES_IDX_MEM_DATA 8'hA9
`define HES_IDX_GPIO 8'hAC
`define HES_IDX_STRAP 8'hAD
// field positions
`define HES_BIT_DDSWAP 6
`define HES_BIT_PS_EN 0
`define HES_BIT_MC_DOWN 3
`define HES_EV_FRAME 0
`define HES_EV_RDREF 1
`define HES_EV_PSWR 2
// reset values
`define HES_RST_DISP_CTRL 8'h00
`define HES_RST_PS_EN 1'b1
`define HES_RST_MASK 3'h0
// pwm clock half period in pclk cycles
`define HES_PWM_HALF 8'h04
`endif

// File: hes_buf.v
// flip-flop display buffer with one host port and one refresh read port
module hes_buf #(
   parameter ADDR_W = 6
) (
   input wire pclk, // clock
   input wire presetn, // async reset, active low
   input wire we, // host write strobe
   input wire [ADDR_W-1:0] waddr, // host write index
   input wire [15:0] wdata, // word as stored
   input wire [ADDR_W-1:0] haddr, // host read index
   output wire [15:0] hdata, // host read word
   input wire [ADDR_W-1:0] raddr, // refresh read index
   output wire [15:0] rdata // refresh read word
);
   reg [15:0] mem_ff [0:(1<<ADDR_W)-1];
   integer i;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
            mem_ff[i] <= 16'h0000;
         end
      end else if (we) begin
         mem_ff[waddr] <= wdata;
      end
   end

   assign hdata = mem_ff[haddr];
   assign rdata = mem_ff[raddr];
endmodule // hes_buf

// File: hes_refresh.v
// display refresh sequencer: walks the buffer and drives the panel
module hes_refresh #(
   parameter ADDR_W = 6,
   parameter LINE_LEN = 8
) (
   input wire pclk, // clock
   input wire presetn, // async reset, active low
   input wire run, // refresh allowed (not in power save)
   input wire swap_en, // second byte swap of stored pixels
   input wire [15:0] rd_data, // buffer word at rd_addr
   output reg [ADDR_W-1:0] rd_addr, // buffer read index
   output reg [15:0] pixel, // panel data
   output reg pix_clk, // panel shift clock
   output reg line_sync, // line pulse
   output reg frame_sync, // frame pulse
   output reg frame_done // one-cycle end of frame event
);
   reg [7:0] col_ff;

   function [15:0] swap16;
      input [15:0] d;
      begin
         swap16 = {d[7:0], d[15:8]};
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_addr <= {ADDR_W{1'b0}};
         col_ff <= 8'h00;
         pixel <= 16'h0000;
         pix_clk <= 1'b0;
         line_sync <= 1'b0;
         frame_sync <= 1'b0;
         frame_done <= 1'b0;
      end else if (!run) begin
         // no buffer reads and every panel output low
         rd_addr <= {ADDR_W{1'b0}}; // RQ7 RQ10
         col_ff <= 8'h00;
         pixel <= 16'h0000; // RQ10
         pix_clk <= 1'b0;
         line_sync <= 1'b0;
         frame_sync <= 1'b0;
         frame_done <= 1'b0;
      end else begin
         pixel <= swap_en ? swap16(rd_data) : rd_data; // RQ4
         pix_clk <= ~pix_clk;
         rd_addr <= rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
         line_sync <= (col_ff == LINE_LEN[7:0] - 8'h01);
         col_ff <= (col_ff == LINE_LEN[7:0] - 8'h01) ? 8'h00 : col_ff + 8'h01;
         frame_sync <= (rd_addr == {ADDR_W{1'b1}});
         frame_done <= (rd_addr == {ADDR_W{1'b1}});
      end
   end
endmodule // hes_refresh

// File: hes_host_port.v
// host port of the display controller: bus byte swap, power save, registers over APB
//
// Summary of operation
// [RQ1] A bus-endian strap caught high at reset makes every host data word to or from buffer or registers byte-swapped; the code swaps buffer words only.
// [RQ2] In big-endian mode the even-addressed byte of a 16-bit host word sits in its upper half, the odd one in its lower.
// [RQ3] Software sets the display-data swap control (bit 6 at index 71h) to one for 16 bpp in big-endian mode.
// [RQ4] With display-data swap on, refresh swaps each stored 16-bit pixel again before it reaches the panel.
// [RQ5] Software clears the display-data swap control for 1, 2, 4 and 8 bpp, where only bus data is swapped.
// [RQ6] Power save is entered while bit 0 at index A0h is set and left when it is cleared.
// [RQ7] In power save the panel is powered down and refresh makes no buffer accesses.
// [RQ8] In power save host buffer reads are refused while register and lookup accesses still work.
// [RQ9] In power save a host buffer write briefly wakes the memory controller so the write completes.
// [RQ10] In power save the sequencer stops, the display is inactive, panel outputs are low and the pwm clock stops.
// [RQ11] In power save pins used for panel timing are low, while pins used as general I/O stay writable.
// [RQ12] Bit 3 at index A0h reads whether the memory controller is powered down.
// [RQ13] After any reset the block is in power save with the enable reading as set.
// [RQ14] Software programs all configuration first and only then clears the power-save enable.
// [RQ15] The pin-function strap is caught as reset is released.
// [RQ16] The captured bus-endian strap holds until the next reset, untouched by register writes.
`include "hes_map.vh"
module hes_host_port #(
   parameter ADDR_W = 6,
   parameter LINE_LEN = 8,
   parameter GPIO_W = 4
) (
   input wire pclk, // apb clock, 40 MHz
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction
   input wire [9:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire bus_endian_strap, // 1 = big-endian host bus
   input wire pin_function_strap, // 1 = gpio pins carry panel timing
   output reg irq, // level interrupt
   output reg [15:0] panel_data, // panel pixel data
   output reg panel_clk, // panel shift clock
   output reg panel_line, // panel line pulse
   output reg panel_frame, // panel frame pulse
   output reg panel_power, // panel power enable
   output reg pwm_clock_out, // pwm clock
   input wire [GPIO_W-1:0] gpio_in, // gpio pin levels
   output reg [GPIO_W-1:0] gpio_out, // gpio pin drive value
   output reg [GPIO_W-1:0] gpio_oe // gpio pin drive enable
);

   // ****************************************
   // helpers
   // ****************************************
   function [15:0] swap16;
      input [15:0] d;
      begin
         swap16 = {d[7:0], d[15:8]};
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg be_ff;
   reg pinfn_ff;
   reg strap_done_ff;
   reg [7:0] disp_ctrl_ff;
   reg ps_en_ff;
   reg mc_down_ff;
   reg [2:0] irq_stat_ff;
   reg [2:0] irq_mask_ff;
   reg [ADDR_W-1:0] mem_addr_ff;
   reg [GPIO_W-1:0] gpio_val_ff;
   reg [GPIO_W-1:0] gpio_dir_ff;
   reg [7:0] pwm_cnt_ff;
   reg pwm_ff;

   wire [7:0] idx = paddr[9:2];
   wire setup_acc = psel & penable & ~pready;
   wire done_acc = psel & penable & pready;
   wire wr_done = done_acc & pwrite;
   wire rd_done = done_acc & ~pwrite;

   wire buf_we;
   wire [15:0] buf_hdata;
   wire [15:0] buf_rdata;
   wire [ADDR_W-1:0] ref_addr;
   wire [15:0] ref_pixel;
   wire ref_clk;
   wire ref_line;
   wire ref_frame;
   wire ref_done;

   reg mapped;
   reg [31:0] rd_mux;
   reg rd_refused;
   reg [2:0] nxt_irq_stat;
   reg [15:0] host_word;

   // ****************************************
   // straps
   // ****************************************
   // caught by the first clock after release, so reset only loads constants
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         be_ff <= 1'b0;
         pinfn_ff <= 1'b0;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         be_ff <= bus_endian_strap; // RQ1 RQ16
         pinfn_ff <= pin_function_strap; // RQ15
         strap_done_ff <= 1'b1;
      end
   end

   // ****************************************
   // host data lane ordering
   // ****************************************
   // little-endian inside; a big-endian host gets its even byte in the upper half
   always @* begin
      host_word = be_ff ? swap16(pwdata[15:0]) : pwdata[15:0]; // RQ1 RQ2
   end

   // ****************************************
   // apb decode and read mux
   // ****************************************
   always @* begin
      mapped = 1'b1;
      rd_refused = 1'b0;
      rd_mux = 32'h00000000;
      case (idx)
         `HES_IDX_DISP_CTRL: begin
            rd_mux = {24'h000000, disp_ctrl_ff};
         end
         `HES_IDX_PSAVE: begin
            rd_mux = {28'h0000000, mc_down_ff, 2'b00, ps_en_ff}; // RQ12
         end
         `HES_IDX_IRQ_STAT: begin
            rd_mux = {29'h00000000, irq_stat_ff};
         end
         `HES_IDX_IRQ_MASK: begin
            rd_mux = {29'h00000000, irq_mask_ff};
         end
         `HES_IDX_MEM_ADDR: begin
            rd_mux[ADDR_W-1:0] = mem_addr_ff;
         end
         `HES_IDX_MEM_DATA: begin
            // buffer reads need the memory controller, which is down in power save
            rd_refused = ps_en_ff & ~pwrite; // RQ8
            rd_mux[15:0] = (be_ff ? swap16(buf_hdata) : buf_hdata) & {16{~ps_en_ff}}; // RQ1 RQ2
         end
         `HES_IDX_GPIO: begin
            rd_mux[GPIO_W-1:0] = gpio_in;
            rd_mux[2*GPIO_W-1:GPIO_W] = gpio_dir_ff;
            rd_mux[3*GPIO_W-1:2*GPIO_W] = gpio_val_ff;
         end
         `HES_IDX_STRAP: begin
            rd_mux = {30'h00000000, pinfn_ff, be_ff};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ****************************************
   // apb answer: one wait cycle, then pready
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_acc;
         if (setup_acc) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= ~mapped | rd_refused; // RQ8
         end else begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_ctrl_ff <= `HES_RST_DISP_CTRL;
         ps_en_ff <= `HES_RST_PS_EN; // RQ13
         irq_mask_ff <= `HES_RST_MASK;
         mem_addr_ff <= {ADDR_W{1'b0}};
         gpio_val_ff <= {GPIO_W{1'b0}};
         gpio_dir_ff <= {GPIO_W{1'b0}};
      end else if (wr_done) begin
         case (idx)
            `HES_IDX_DISP_CTRL: begin
               disp_ctrl_ff <= pwdata[7:0]; // RQ3 RQ5
            end
            `HES_IDX_PSAVE: begin
               ps_en_ff <= pwdata[`HES_BIT_PS_EN]; // RQ6
            end
            `HES_IDX_IRQ_MASK: begin
               irq_mask_ff <= pwdata[2:0];
            end
            `HES_IDX_MEM_ADDR: begin
               mem_addr_ff <= pwdata[ADDR_W-1:0];
            end
            `HES_IDX_MEM_DATA: begin
               mem_addr_ff <= mem_addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
            `HES_IDX_GPIO: begin
               // gpio stays writable in power save
               gpio_dir_ff <= pwdata[2*GPIO_W-1:GPIO_W]; // RQ11
               gpio_val_ff <= pwdata[3*GPIO_W-1:2*GPIO_W]; // RQ11
            end
            default: begin
               mem_addr_ff <= mem_addr_ff;
            end
         endcase
      end else if (rd_done && idx == `HES_IDX_MEM_DATA && !ps_en_ff) begin
         mem_addr_ff <= mem_addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
   end

   // ****************************************
   // memory controller power state
   // ****************************************
   // a buffer write in power save wakes the controller for one cycle only, the cycle after the write strobe
   assign buf_we = wr_done & (idx == `HES_IDX_MEM_DATA); // RQ9

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_down_ff <= 1'b1;
      end else begin
         mc_down_ff <= ps_en_ff & ~buf_we; // RQ9 RQ12
      end
   end

   // ****************************************
   // interrupt status, cleared by read, set wins
   // ****************************************
   always @* begin
      nxt_irq_stat = irq_stat_ff;
      if (rd_done && idx == `HES_IDX_IRQ_STAT) begin
         nxt_irq_stat = 3'h0;
      end
      if (ref_done) begin
         nxt_irq_stat[`HES_EV_FRAME] = 1'b1;
      end
      if (rd_done && rd_refused) begin
         nxt_irq_stat[`HES_EV_RDREF] = 1'b1;
      end
      if (buf_we && ps_en_ff) begin
         nxt_irq_stat[`HES_EV_PSWR] = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   // ****************************************
   // display buffer and refresh
   // ****************************************
   hes_buf #(
      .ADDR_W(ADDR_W)
   ) u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .we(buf_we),
      .waddr(mem_addr_ff),
      .wdata(host_word),
      .haddr(mem_addr_ff),
      .hdata(buf_hdata),
      .raddr(ref_addr),
      .rdata(buf_rdata)
   );

   hes_refresh #(
      .ADDR_W(ADDR_W),
      .LINE_LEN(LINE_LEN)
   ) u_refresh (
      .pclk(pclk),
      .presetn(presetn),
      .run(~ps_en_ff), // RQ7 RQ10
      .swap_en(disp_ctrl_ff[`HES_BIT_DDSWAP]), // RQ4
      .rd_data(buf_rdata),
      .rd_addr(ref_addr),
      .pixel(ref_pixel),
      .pix_clk(ref_clk),
      .line_sync(ref_line),
      .frame_sync(ref_frame),
      .frame_done(ref_done)
   );

   // ****************************************
   // panel, pwm and gpio pins
   // ****************************************
   // refresh outputs are already low in power save; registering adds one cycle of latency
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_data <= 16'h0000;
         panel_clk <= 1'b0;
         panel_line <= 1'b0;
         panel_frame <= 1'b0;
         panel_power <= 1'b0;
         pwm_cnt_ff <= 8'h00;
         pwm_ff <= 1'b0;
         pwm_clock_out <= 1'b0;
         gpio_out <= {GPIO_W{1'b0}};
         gpio_oe <= {GPIO_W{1'b0}};
      end else begin
         panel_data <= ref_pixel; // RQ10
         panel_clk <= ref_clk;
         panel_line <= ref_line;
         panel_frame <= ref_frame;
         panel_power <= ~ps_en_ff; // RQ7
         if (ps_en_ff) begin
            pwm_cnt_ff <= 8'h00; // RQ10
            pwm_ff <= 1'b0;
         end else if (pwm_cnt_ff == `HES_PWM_HALF - 8'h01) begin
            pwm_cnt_ff <= 8'h00;
            pwm_ff <= ~pwm_ff;
         end else begin
            pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
         end
         pwm_clock_out <= pwm_ff & ~ps_en_ff; // RQ10
         if (pinfn_ff) begin
            // panel timing pins: forced low in power save by the ps_en_ff mask
            gpio_out <= {{(GPIO_W-3){1'b0}}, ref_clk, ref_frame, ref_line} & {GPIO_W{~ps_en_ff}}; // RQ11
            gpio_oe <= {GPIO_W{1'b1}};
         end else begin
            gpio_out <= gpio_val_ff; // RQ11
            gpio_oe <= gpio_dir_ff;
         end
      end
   end
endmodule // hes_host_port

// File: hes_host_port_monitor.sv
// checker of the host port: bus timing, power save and strap capture
`include "hes_map.vh"
module hes_host_port_monitor #(
   parameter GPIO_W = 4
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic [9:0] paddr, // byte address
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic bus_endian_strap, // endian strap
   input wire logic pin_function_strap, // pin strap
   input wire logic [15:0] panel_data, // pixel
   input wire logic panel_clk, // shift clock
   input wire logic panel_line, // line pulse
   input wire logic panel_frame, // frame pulse
   input wire logic panel_power, // panel power
   input wire logic pwm_clock_out, // pwm clock
   input wire logic [GPIO_W-1:0] gpio_out // gpio drive
);
   wire logic [7:0] idx = paddr[9:2];
   logic seen_ff;
   logic [1:0] cap_ff;
   // ************************************************************
   // strap copy and properties
   // ************************************************************
   // straps are copied on the first edge after release, the moment the port takes them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_ff <= 1'b0;
         cap_ff <= 2'h0;
      end else if (!seen_ff) begin
         seen_ff <= 1'b1;
         cap_ff <= {pin_function_strap, bus_endian_strap};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // panel_power lags the mode by a cycle, so wait three low cycles before judging
   sequence s_saved;
      (!panel_power) [*3];
   endsequence
   AST_READY_TIME: assert property (psel && $rose(penable) |=> pready)
      else $error("ready late");
   AST_PANEL_LOW: assert property (s_saved |-> panel_data == 16'h0000 && !panel_clk && !panel_line && !panel_frame)
      else $error("panel active in save");
   AST_PWM_STOP: assert property (s_saved |-> !pwm_clock_out)
      else $error("pwm runs in save");
   AST_GPIO_LOW: assert property (s_saved ##0 cap_ff[1] |-> gpio_out[2:0] == 3'h0)
      else $error("timing pins driven in save");
   AST_BUF_READ: assert property (pready && !pwrite && idx == `HES_IDX_MEM_DATA |-> pslverr == !panel_power)
      else $error("buffer read error wrong");
   AST_REG_OK: assert property (pready && (idx == `HES_IDX_DISP_CTRL || idx == `HES_IDX_PSAVE) |-> !pslverr)
      else $error("register refused");
   AST_BUF_WRITE: assert property (pready && pwrite && idx == `HES_IDX_MEM_DATA |-> !pslverr)
      else $error("buffer write refused");
   AST_PS_FLAGS: assert property (pready && !pwrite && idx == `HES_IDX_PSAVE |-> prdata[0] == !panel_power && prdata[3] == !panel_power)
      else $error("save flags wrong");
   AST_PS_WRITE: assert property (pready && pwrite && idx == `HES_IDX_PSAVE |-> ##2 panel_power == !$past(pwdata[0], 2))
      else $error("save write ignored");
   AST_STRAP: assert property (pready && !pwrite && idx == `HES_IDX_STRAP |-> prdata[1:0] == cap_ff)
      else $error("strap read wrong");
   COV_REFUSED: cover property (pready && pslverr && idx == `HES_IDX_MEM_DATA);
   COV_PS_WRITE: cover property (pready && pwrite && idx == `HES_IDX_MEM_DATA && !panel_power);
   COV_RUN: cover property ($rose(panel_power));
endmodule // hes_host_port_monitor
bind hes_host_port hes_host_port_monitor #(.GPIO_W(GPIO_W)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_endian_strap, .pin_function_strap, .panel_data, .panel_clk,
   .panel_line, .panel_frame, .panel_power, .pwm_clock_out, .gpio_out);

// File: hes_host_model.sv
// apb host model that issues register and buffer transfers
module hes_host_model (
   input wire logic pclk, // clock
   output logic psel, // select
   output logic penable, // access phase
   output logic pwrite, // direction
   output logic [9:0] paddr, // byte address
   output logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr // error
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // transfer
   // ************************************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h00000000;
   end
   // request held until pready is seen; one idle cycle between transfers keeps it simple
   task automatic xfer(input logic wr, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {i, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // hes_host_model

// File: hes_host_port_bench.sv
// self-checking bench of the host port
`include "hes_map.vh"
module hes_host_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, bus_endian_strap, pin_function_strap, irq;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] panel_data;
   logic panel_clk, panel_line, panel_frame, panel_power, pwm_clock_out;
   logic [3:0] gpio_in, gpio_out, gpio_oe;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   hes_host_port u_hes_host_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .bus_endian_strap, .pin_function_strap, .irq, .panel_data, .panel_clk, .panel_line, .panel_frame,
      .panel_power, .pwm_clock_out, .gpio_in, .gpio_out, .gpio_oe);
   hes_host_model u_hes_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   always #12.5 pclk = ~pclk;
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic tally_and_finish();
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      u_hes_host_model.xfer(1'b1, i, d, r, e);
   endtask
   task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic e);
      u_hes_host_model.xfer(1'b0, i, 32'h00000000, d, e);
   endtask
   // one reset with the given straps, then every check; the stored word shows the bus swap
   task automatic run(input logic be, input logic pf);
      logic [31:0] d;
      logic e, p;
      logic [15:0] st;
      st = be ? 16'h2211 : 16'h1122;
      @(posedge pclk);
      bus_endian_strap <= be;
      pin_function_strap <= pf;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({panel_power, pwm_clock_out, panel_clk, panel_line, panel_frame, panel_data}, 0, "panel off");
      rd(`HES_IDX_PSAVE, d, e);
      check(d[3:0] & 4'h9, 4'h9, "save after reset");
      rd(`HES_IDX_STRAP, d, e);
      check(d[1:0], {pf, be}, "strap");
      bus_endian_strap <= ~be;
      wr(`HES_IDX_STRAP, 32'h00000000);
      rd(`HES_IDX_STRAP, d, e);
      check(d[1:0], {pf, be}, "strap held");
      bus_endian_strap <= be;
      rd(8'h00, d, e);
      check(e, 1'b1, "unmapped");
      wr(`HES_IDX_IRQ_MASK, 32'h00000007);
      wr(`HES_IDX_MEM_ADDR, 32'h00000000);
      repeat (64) wr(`HES_IDX_MEM_DATA, 32'h00001122);
      repeat (2) @(posedge pclk);
      check(irq, 1'b1, "irq on save write");
      wr(`HES_IDX_IRQ_MASK, 32'h00000001);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0, "irq masked");
      wr(`HES_IDX_IRQ_MASK, 32'h00000007);
      wr(`HES_IDX_MEM_ADDR, 32'h00000000);
      rd(`HES_IDX_MEM_DATA, d, e);
      check(e, 1'b1, "read in save");
      rd(`HES_IDX_IRQ_STAT, d, e);
      check(d[2:0], 3'h6, "status");
      repeat (2) @(posedge pclk);
      check(irq, 1'b0, "irq cleared");
      wr(`HES_IDX_GPIO, 32'h00000AF0);
      repeat (2) @(posedge pclk);
      check({gpio_oe, gpio_out}, {4'hF, pf ? 4'h0 : 4'hA}, "gpio in save");
      rd(`HES_IDX_GPIO, d, e);
      check(d[3:0], gpio_in, "gpio pins");
      for (int sw = 0; sw < 2; sw++) begin
         wr(`HES_IDX_DISP_CTRL, sw ? 32'h00000040 : 32'h00000000);
         wr(`HES_IDX_PSAVE, 32'h00000000);
         p = 1'b0;
         repeat (10) begin
            @(posedge pclk);
            p = p | pwm_clock_out;
         end
         check(panel_data, sw ? {st[7:0], st[15:8]} : st, "pixel");
         check({panel_power, p}, 2'h3, "running");
         rd(`HES_IDX_PSAVE, d, e);
         check(d[3:0], 4'h0, "save flags clear");
         wr(`HES_IDX_MEM_ADDR, 32'h00000000);
         rd(`HES_IDX_MEM_DATA, d, e);
         check({e, d[15:0]}, {1'b0, 16'h1122}, "readback");
         repeat (70) @(posedge pclk);
         rd(`HES_IDX_IRQ_STAT, d, e);
         check(d[0], 1'b1, "frame event");
         wr(`HES_IDX_PSAVE, 32'h00000001);
         repeat (4) @(posedge pclk);
         check({panel_power, pwm_clock_out, panel_data}, 0, "panel off again");
      end
   endtask
   // ************************************************************
   // sequence and hang guard
   // ************************************************************
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      presetn = 1'b0;
      bus_endian_strap = 1'b0;
      pin_function_strap = 1'b0;
      gpio_in = 4'h6;
      run(1'b1, 1'b0);
      run(1'b0, 1'b1);
      tally_and_finish();
   end
endmodule // hes_host_port_bench
